// file: rtl/wdr_pkg.sv
package wdr_pkg;

  // apb register map, byte addresses
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_CFG     = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h0c;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFF_COUNT   = 8'h14;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // control keys, written to the low byte of ctrl
  localparam int         KEY_W       = 8;
  localparam logic [7:0] KEY_RESTART = 8'ha5;
  localparam logic [7:0] KEY_DISABLE = 8'hde;
  localparam logic [7:0] KEY_LOCK    = 8'hc3;

  // ctrl read-back fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_LOCK_BIT = 1;

  // timeout select: limit is 2**(SEL_BASE + sel) low-frequency ticks
  localparam int         SEL_W    = 3;
  localparam int         SEL_BASE = 10;
  localparam logic [2:0] SEL_MAX  = 3'h7;
  localparam int         CNT_W    = 17;

  // status / irq bit positions
  localparam int EV_W          = 2;
  localparam int EV_TIMEOUT    = 0;
  localparam int EV_REJECTED   = 1;

  // nominal clock rates
  localparam int CLK_FREQ_HZ = 25000000;
  localparam int LF_FREQ_HZ  = 80000;

  function automatic logic [CNT_W-1:0] timeout_limit(input logic [SEL_W-1:0] sel);
    logic [CNT_W:0] one_hot;
    one_hot = '0;
    one_hot[SEL_BASE + int'(sel)] = 1'b1;
    timeout_limit = CNT_W'(one_hot - 1'b1);
  endfunction

  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    addr_is = (addr == off);
  endfunction

endpackage

// file: rtl/wdr_counter.sv
`timescale 1ns/10ps
module wdr_counter #(
  parameter int CW = wdr_pkg::CNT_W
) (
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  input  wire logic                       tick_i,
  input  wire logic                       clear_i,
  input  wire logic                       run_i,
  input  wire logic [wdr_pkg::SEL_W-1:0]  sel_i,
  output logic      [CW-1:0]              count_o,
  output logic                            expire_o
);

  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  wire  [CW-1:0] limit;
  wire           at_limit;

  assign limit    = CW'(wdr_pkg::timeout_limit(sel_i));
  // a select lowered below the current count expires on the next tick
  assign at_limit = (count_r >= limit);
  assign expire_o = run_i & tick_i & ~clear_i & at_limit;

  // counts only on low-frequency ticks
  assign count_nxt = clear_i  ? '0 :
                     expire_o ? '0 :
                     (run_i & tick_i) ? CW'(count_r + 1'b1) : count_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  assign count_o = count_r;

endmodule

// file: rtl/wdr_watchdog_unit.sv
//Contract
// - counter overflow raises a system reset request.
// - after reset the watchdog runs, with the longest timeout selected.
// - software may disable the watchdog or lock it running.
// - once locked, disable attempts are ignored until system reset.
// - once locked, cfg timeout select writes are rejected; irq enable and irq clear writes still apply.
// - watchdog reset never drives the external reset pin.
// - counter advances only on the 80 kHz low-frequency oscillator.
`timescale 1ns/10ps
module wdr_watchdog_unit (
  input  wire logic                        clk_i,
  input  wire logic                        arst_n_i,
  input  wire logic                        low_freq_osc_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [wdr_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [wdr_pkg::DATA_W-1:0]  pwdata_i,
  output logic      [wdr_pkg::DATA_W-1:0]  prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  output logic                             irq_o,
  output logic                             rst_req_o
);

  // low-frequency oscillator edge detect
  logic lf_prev_r;
  wire  lf_tick;

  // apb
  logic                        pready_r;
  logic                        pslverr_r;
  logic [wdr_pkg::DATA_W-1:0]  prdata_r;
  wire                         setup_acc;
  wire                         acc_done;
  wire                         wr_done;
  wire                         sel_ctrl;
  wire                         sel_cfg;
  wire                         sel_status;
  wire                         sel_irq_en;
  wire                         sel_irq_clr;
  wire                         sel_count;
  wire                         mapped;
  wire  [wdr_pkg::DATA_W-1:0]  rd_val;

  // watchdog control state
  logic                        en_r;
  logic                        en_nxt;
  logic                        lock_r;
  logic                        lock_nxt;
  logic [wdr_pkg::SEL_W-1:0]   sel_r;
  logic [wdr_pkg::SEL_W-1:0]   sel_nxt;
  logic                        rst_req_r;
  wire  [wdr_pkg::KEY_W-1:0]   key;
  wire                         wr_ctrl;
  wire                         wr_cfg;
  wire                         key_restart;
  wire                         key_disable;
  wire                         key_lock;
  wire                         any_key;
  wire                         cnt_clear;
  wire  [wdr_pkg::CNT_W-1:0]   count;
  wire                         expire;

  // events and interrupt
  logic [wdr_pkg::EV_W-1:0]    sts_r;
  logic [wdr_pkg::EV_W-1:0]    sts_nxt;
  logic [wdr_pkg::EV_W-1:0]    ien_r;
  logic [wdr_pkg::EV_W-1:0]    ien_nxt;
  logic                        irq_r;
  wire  [wdr_pkg::EV_W-1:0]    ev;
  wire  [wdr_pkg::EV_W-1:0]    clr_mask;

  // counting edge from the low-frequency oscillator
  assign lf_tick = low_freq_osc_i & ~lf_prev_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    // resets high so a pin already high at release is not counted as a tick
    if (!arst_n_i)
      lf_prev_r <= 1'b1;
    else
      lf_prev_r <= low_freq_osc_i;
  end

  // one wait state: pready is registered, so the access phase lasts two cycles
  assign setup_acc = psel_i & penable_i & ~pready_r;
  assign acc_done  = psel_i & penable_i & pready_r;
  assign wr_done   = acc_done & pwrite_i;

  assign sel_ctrl    = wdr_pkg::addr_is(paddr_i, wdr_pkg::OFF_CTRL);
  assign sel_cfg     = wdr_pkg::addr_is(paddr_i, wdr_pkg::OFF_CFG);
  assign sel_status  = wdr_pkg::addr_is(paddr_i, wdr_pkg::OFF_STATUS);
  assign sel_irq_en  = wdr_pkg::addr_is(paddr_i, wdr_pkg::OFF_IRQ_EN);
  assign sel_irq_clr = wdr_pkg::addr_is(paddr_i, wdr_pkg::OFF_IRQ_CLR);
  assign sel_count   = wdr_pkg::addr_is(paddr_i, wdr_pkg::OFF_COUNT);
  assign mapped      = sel_ctrl | sel_cfg | sel_status | sel_irq_en | sel_irq_clr | sel_count;

  assign rd_val = sel_ctrl   ? wdr_pkg::DATA_W'({lock_r, en_r}) :
                  sel_cfg    ? wdr_pkg::DATA_W'(sel_r) :
                  sel_status ? wdr_pkg::DATA_W'(sts_r) :
                  sel_irq_en ? wdr_pkg::DATA_W'(ien_r) :
                  sel_count  ? wdr_pkg::DATA_W'(count) : '0;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else
    begin
      pready_r  <= setup_acc;
      pslverr_r <= setup_acc & ~mapped;
      prdata_r  <= (setup_acc & ~pwrite_i) ? rd_val : '0;
    end
  end

  // key decode on the ctrl low byte
  assign key         = pwdata_i[wdr_pkg::KEY_W-1:0];
  assign wr_ctrl     = wr_done & sel_ctrl;
  assign wr_cfg      = wr_done & sel_cfg;
  assign key_restart = wr_ctrl & (key == wdr_pkg::KEY_RESTART);
  assign key_disable = wr_ctrl & (key == wdr_pkg::KEY_DISABLE);
  assign key_lock    = wr_ctrl & (key == wdr_pkg::KEY_LOCK);
  assign any_key     = key_restart | key_disable | key_lock;

  // restart or lock starts it, disable stops it unless locked
  assign en_nxt   = (key_restart | key_lock) ? 1'b1 :
                    (key_disable & ~lock_r)  ? 1'b0 : en_r;
  assign lock_nxt = lock_r | key_lock;

  assign sel_nxt = (wr_cfg & ~lock_r) ? pwdata_i[wdr_pkg::SEL_W-1:0] : sel_r;

  // restarting, and a stopped watchdog, both hold the count at zero
  assign cnt_clear = key_restart | ~en_r;

  // comes out of reset running at the longest timeout
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      en_r   <= 1'b1;
      lock_r <= 1'b0;
      sel_r  <= wdr_pkg::SEL_MAX;
    end
    else
    begin
      en_r   <= en_nxt;
      lock_r <= lock_nxt;
      sel_r  <= sel_nxt;
    end
  end

  wdr_counter #(
    .CW (wdr_pkg::CNT_W)
  ) u_counter (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .tick_i   (lf_tick),
    .clear_i  (cnt_clear),
    .run_i    (en_r),
    .sel_i    (sel_r),
    .count_o  (count),
    .expire_o (expire)
  );

  // overflow latches the reset request until the system resets us
  // only an internal request; no reset pin is driven from here
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rst_req_r <= 1'b0;
    else
      rst_req_r <= rst_req_r | expire;
  end

  // sticky events; a set in the clearing cycle wins
  assign ev[wdr_pkg::EV_TIMEOUT]  = expire;
  assign ev[wdr_pkg::EV_REJECTED] = lock_r & (wr_cfg | key_disable);
  assign clr_mask = (wr_done & sel_irq_clr) ? pwdata_i[wdr_pkg::EV_W-1:0] : '0;
  assign sts_nxt  = (sts_r & ~clr_mask) | ev;
  assign ien_nxt  = (wr_done & sel_irq_en) ? pwdata_i[wdr_pkg::EV_W-1:0] : ien_r;

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sts_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
    end
    else
    begin
      sts_r <= sts_nxt;
      ien_r <= ien_nxt;
      irq_r <= |(sts_nxt & ien_nxt);
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = pready_r;
  assign pslverr_o = pslverr_r;
  assign irq_o     = irq_r;
  assign rst_req_o = rst_req_r;

  // helper: high only in the first cycle after reset release
  logic first_r;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      first_r <= 1'b1;
    else
      first_r <= 1'b0;
  end

  AST_OVF_RESET: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    expire |=> rst_req_o [*3]
  ) else $error("overflow did not raise a held reset request");

  AST_REQ_CAUSE: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    $rose(rst_req_o) |-> $past(expire)
  ) else $error("reset request rose without an overflow");

  AST_RESET_DEFAULT: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    first_r |-> (en_r && !lock_r && sel_r == wdr_pkg::SEL_MAX && !rst_req_o)
  ) else $error("watchdog not running at longest timeout after reset");

  AST_DISABLE: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (key_disable && !lock_r) |=> !en_r
  ) else $error("disable key did not stop the watchdog");

  AST_LOCK_SET: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    key_lock |=> (lock_r && en_r)
  ) else $error("lock key did not lock the watchdog running");

  AST_LOCK_HOLDS: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    lock_r |=> (lock_r && en_r)
  ) else $error("locked watchdog was released or disabled");

  AST_CFG_FROZEN: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (lock_r && wr_cfg) |=> ($stable(sel_r) && sts_r[wdr_pkg::EV_REJECTED])
  ) else $error("locked configuration changed or rejection not flagged");

  AST_LF_ONLY: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (!lf_tick && !cnt_clear) |=> $stable(count)
  ) else $error("counter moved without a low-frequency tick");

  AST_LIMIT: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    expire |-> (count >= wdr_pkg::timeout_limit(sel_r))
  ) else $error("overflow before the selected power-of-two count");

  AST_BAD_KEY: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (wr_ctrl && !any_key) |=> ($stable(en_r) && $stable(lock_r))
  ) else $error("unrecognised ctrl value changed the watchdog");

  AST_RESTART: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    key_restart |=> (count == '0 && en_r)
  ) else $error("restart key did not clear the counter");

  AST_IRQ: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    ##1 (irq_o == |(sts_r & ien_r))
  ) else $error("interrupt output does not follow enabled status");

  AST_APB_READY: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    setup_acc |=> pready_o ##1 !pready_o
  ) else $error("pready not a single cycle after one wait state");

  AST_LIMIT_HIT: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (en_r && lf_tick && !cnt_clear && count == wdr_pkg::timeout_limit(sel_r)) |-> expire
  ) else $error("count reached the selected limit without an overflow");

  AST_LOCKED_DISABLE: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (key_disable && lock_r) |=> (en_r && sts_r[wdr_pkg::EV_REJECTED])
  ) else $error("disable key acted on a locked watchdog");

  AST_SLVERR: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    (setup_acc && !mapped) |=> (pready_o && pslverr_o && prdata_o == '0)
  ) else $error("unmapped access not answered with an error");

  AST_RDATA_QUIET: assert property (
    @(posedge clk_i) disable iff (!arst_n_i)
    !pready_o |-> (prdata_o == '0 && !pslverr_o)
  ) else $error("read data or error shown outside the ready cycle");

endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk_i;
  logic        arst_n_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        irq_o;
  logic        rst_req_o;
  logic [2:0]  lf_cnt = 3'h0;
  logic        lf_run;
  int          tick_n = 0;
  int          t0;
  int          error_cnt;
  int          n_tests;
  logic [31:0] rdat;
  logic        rerr;

  wdr_watchdog_unit wdr_watchdog_unit_i (
    .clk_i          (clk_i),
    .arst_n_i       (arst_n_i),
    .low_freq_osc_i (lf_cnt[2]),
    .psel_i         (psel_i),
    .penable_i      (penable_i),
    .pwrite_i       (pwrite_i),
    .paddr_i        (paddr_i),
    .pwdata_i       (pwdata_i),
    .prdata_o       (prdata_o),
    .pready_o       (pready_o),
    .pslverr_o      (pslverr_o),
    .irq_o          (irq_o),
    .rst_req_o      (rst_req_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // slow oscillator stand-in: one tick every 8 clocks keeps 1024-tick timeouts short
  always @(posedge clk_i)
  begin
    if (lf_run)
    begin
      lf_cnt <= lf_cnt + 3'h1;
      if (lf_cnt == 3'h3)
        tick_n <= tick_n + 1;
    end
  end

  task automatic stop_test;
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        error_cnt++;
        stop_test();
      end
      @(posedge clk_i);
    end
    rdat = prdata_o;
    rerr = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask

  task automatic do_rst;
    arst_n_i <= 1'b0;
    wt(6);
    arst_n_i <= 1'b1;
  endtask

  initial
  begin
    int i;
    arst_n_i  = 1'b0;
    psel_i    = 1'b0;
    penable_i = 1'b0;
    pwrite_i  = 1'b0;
    paddr_i   = 8'h00;
    pwdata_i  = 32'h0;
    lf_run    = 1'b0;
    error_cnt = 0;
    n_tests   = 0;
    do_rst();
    rd(wdr_pkg::OFF_CTRL, 32'h1);
    rd(wdr_pkg::OFF_CFG, 32'h7);
    rd(wdr_pkg::OFF_STATUS, 32'h0);
    rd(wdr_pkg::OFF_IRQ_EN, 32'h0);
    chk(32'(rst_req_o), 32'h0);
    rd(8'h18, 32'h0);
    chk(32'(rerr), 32'h1);
    for (i = 0; i < 8; i++)
    begin
      wr(wdr_pkg::OFF_CFG, 32'(i));
      rd(wdr_pkg::OFF_CFG, 32'(i));
    end
    wr(wdr_pkg::OFF_CFG, 32'h0);
    // counting follows oscillator ticks only, not the system clock
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_RESTART});
    t0 = tick_n;
    lf_run <= 1'b1;
    wt(200);
    lf_run <= 1'b0;
    wt(60);
    rd(wdr_pkg::OFF_COUNT, 32'(tick_n - t0));
    wr(wdr_pkg::OFF_CTRL, 32'h12);
    rd(wdr_pkg::OFF_COUNT, 32'(tick_n - t0));
    rd(wdr_pkg::OFF_CTRL, 32'h1);
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_DISABLE});
    rd(wdr_pkg::OFF_CTRL, 32'h0);
    lf_run <= 1'b1;
    wt(9000);
    chk(32'(rst_req_o), 32'h0);
    rd(wdr_pkg::OFF_COUNT, 32'h0);
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_RESTART});
    rd(wdr_pkg::OFF_CTRL, 32'h1);
    // restarts well inside the 1024-tick window keep reset away
    repeat (3)
    begin
      wt(6000);
      wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_RESTART});
    end
    chk(32'(rst_req_o), 32'h0);
    wr(wdr_pkg::OFF_IRQ_EN, 32'h3);
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_LOCK});
    rd(wdr_pkg::OFF_CTRL, 32'h3);
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_DISABLE});
    rd(wdr_pkg::OFF_CTRL, 32'h3);
    wr(wdr_pkg::OFF_CFG, 32'h5);
    rd(wdr_pkg::OFF_CFG, 32'h0);
    rd(wdr_pkg::OFF_STATUS, 32'h2);
    wt(2);
    chk(32'(irq_o), 32'h1);
    wr(wdr_pkg::OFF_IRQ_EN, 32'h1);
    wt(2);
    chk(32'(irq_o), 32'h0);
    wr(wdr_pkg::OFF_IRQ_CLR, 32'h2);
    rd(wdr_pkg::OFF_STATUS, 32'h0);
    // exact overflow point: 1024 ticks after a restart with select 0
    lf_run <= 1'b0;
    wt(4);
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_RESTART});
    t0 = tick_n;
    lf_run <= 1'b1;
    i = 0;
    while (rst_req_o !== 1'b1)
    begin
      i++;
      if (i > 10000)
      begin
        error_cnt++;
        stop_test();
      end
      @(posedge clk_i);
    end
    chk(32'(tick_n - t0), 32'd1024);
    wt(3);
    rd(wdr_pkg::OFF_STATUS, 32'h1);
    chk(32'(irq_o), 32'h1);
    chk(32'(rst_req_o), 32'h1);
    do_rst();
    rd(wdr_pkg::OFF_CTRL, 32'h1);
    rd(wdr_pkg::OFF_CFG, 32'h7);
    chk(32'(rst_req_o), 32'h0);
    wr(wdr_pkg::OFF_CTRL, {24'h0, wdr_pkg::KEY_DISABLE});
    rd(wdr_pkg::OFF_CTRL, 32'h0);
    stop_test();
  end
endmodule
